// ---- hw/rwr_reset_ctrl.sv ----
/*
 Reset and wake recovery sequencer with the reset cause status register.
 Assumes the watchdog, oscillator, analog detectors and ports live outside;
 ioscTick is a one-cycle enable marking each internal oscillator cycle.
*/
// The Avalon-MM slave port was decided locally.
// What this block does
// R1: Outside stop, a reset pin low for three clocks starts the reset sequence.
// R2: Stay in reset while the pin is low; leave on next edge after release.
// R3: A pin-initiated reset sets the external-pin flag.
// R4: In reset the pin is driven low as open-drain output until the reset delay ends.
// R5: An internal reset drives the pin low at once until its delay ends.
// R6: Reset lasts 66 oscillator cycles, or 5000 with the crystal enabled.
// R7: Debugger reset request resets all but debugger, self-clears, sets power-on.
// R8: Wake recovery holds the CPU in reset for 66 or 5000 cycles.
// R9: Wake keeps registers except watchdog and oscillator control; selects oscillator.
// R10: After reset or wake the CPU fetches its vector from 0002H and 0003H.
// R11: In stop, watchdog time-out wakes; reset pin or debug pin low fully resets.
// R12: Watchdog time-out in stop sets watchdog and wake flags.
// R13: An enabled port pin edge in stop starts wake and sets the wake flag.
// R14: Port capture is off in stop; pin levels are latched at recovery end.
// R15: In stop, a reset pin low shorter than the filter width is ignored.
// R16: Status is read-only and a read clears the four cause flags.
// R17: Reads at FF0H give status; writes there go to watchdog control.
// R18: Flags in bits 7..4 are power-on, wake, watchdog, external.
// R19: Power-on flag cleared by watchdog time-out, any wake, or a read.
// R20: Wake flag cleared by power-on, watchdog time-out outside stop, or read.
// R21: Watchdog flag cleared by power-on, pin wake or read; read before clearing.
// R22: External flag cleared by power-on, pin wake, or a read.
// R23: The reset pin is synchronised in two stages; reserved status bits read zero.
`timescale 1ns/1ps
module rwr_reset_ctrl
    import rwr_pkg::*;
#(
    parameter int PORTS     = 8,
    parameter int XTAL_CYC  = rwr_pkg::RWR_DELAY_XTAL
) (
    // Clock and reset
    input  wire  logic                  clk,
    input  wire  logic                  rst_n,
    // Avalon-MM slave
    input  wire  rwr_pkg::rwr_bus_req_t bus,
    output logic [31:0]                 readdata,
    output logic                        waitrequest,
    // Reset pin, open drain
    input  wire  logic                  resetPinIn,
    output logic                        resetPinOut,
    output logic                        resetPinOe,
    // Events and ports
    input  wire  rwr_pkg::rwr_event_t   ev,
    input  wire  logic [PORTS-1:0]      wakeEnable,
    input  wire  logic [PORTS-1:0]      portPins,
    // Outputs to the rest of the chip
    output logic                        cpuReset,
    output logic                        systemReset,
    output logic                        wakeDone,
    output logic                        selectIosc,
    output logic                        crystalEnable,
    output logic                        wdtIrqFollow,
    output logic [15:0]                 vectorAddrLo,
    output logic [PORTS-1:0]            portInputData,
    output logic [7:0]                  watchdogControl,
    output logic                        watchdogControlWr
);
    import rwr_pkg::*;

    typedef struct packed {
        rwr_state_t       state;
        logic [1:0]       pinSync;
        logic [3:0]       lowCount;
        logic             pinCaused;
        logic [15:0]      delay;
        logic [3:0]       flags;
        logic             xtal;
        logic             dbgReq;
        logic             wdtPending;
        logic [PORTS-1:0] portLast;
        logic [PORTS-1:0] portData;
        logic [7:0]       wdCtl;
        logic             wdWr;
        logic             wakeDone;
        logic [31:0]      rdata;
        logic             ack;
    } rwr_regs_t;

    rwr_regs_t r;
    rwr_regs_t next_r;

    function automatic logic [15:0] delay_for(input logic x);
        delay_for = x ? 16'(XTAL_CYC) : RWR_DELAY_IOSC_W;
    endfunction : delay_for

    logic pinLow;
    logic pinReset;
    logic portEdge;
    logic busHit;
    logic readStatus;
    logic [3:0] minLow;
    logic       hardReset;
    logic       wdtReset;
    logic       resetReq;

    assign pinLow     = ~r.pinSync[1];
    assign minLow     = ev.stopMode ? 4'(RWR_STOP_FILTER) : 4'(RWR_PIN_LOW_MIN - 1);
    assign pinReset   = pinLow && (r.lowCount >= minLow - 4'h1) && (r.state != RWR_RESET); // [R1] [R15]
    assign portEdge   = ev.stopMode && |((portPins ^ r.portLast) & wakeEnable); // [R13]
    assign busHit     = (bus.read || bus.write) && !r.ack;
    assign readStatus = bus.read && !r.ack && bus.address == RWR_ADDR_STATUS;
    assign hardReset  = ev.porEvent || ev.brownout || r.dbgReq || (ev.stopMode && ev.debugPinLow);
    assign wdtReset   = ev.wdtTimeout && ev.wdtResetMode && !ev.stopMode;
    assign resetReq   = hardReset || pinReset || wdtReset;

    always_comb begin
        next_r          = r;
        next_r.pinSync  = {r.pinSync[0], resetPinIn}; // [R23]
        next_r.ack      = busHit;
        next_r.wdWr     = 1'b0;
        next_r.wakeDone = 1'b0;
        next_r.lowCount = pinLow ? ((r.lowCount == 4'hf) ? r.lowCount : r.lowCount + 4'h1)
                                 : 4'h0;
        if (!ev.stopMode) begin
            next_r.portLast = portPins;
        end
        if (readStatus) begin
            next_r.rdata = {24'h0, r.flags, 4'h0}; // [R16] [R18] [R23]
            next_r.flags = 4'h0; // [R16]
        end else if (bus.read && !r.ack) begin
            next_r.rdata = RWR_READ_ZERO;
        end
        if (bus.write && !r.ack) begin
            if (bus.address == RWR_ADDR_STATUS) begin
                next_r.wdCtl = bus.writedata[7:0]; // [R17]
                next_r.wdWr  = 1'b1;
            end else if (bus.address == RWR_ADDR_CONTROL) begin
                next_r.xtal   = bus.writedata[RWR_CTL_XTAL];
                next_r.dbgReq = bus.writedata[RWR_CTL_DBGRST];
            end
        end
        if (ev.wdtTimeout && !ev.stopMode) begin
            next_r.flags[RWR_BIT_WAKE - 4] = 1'b0; // [R20]
            next_r.flags[RWR_BIT_POR - 4]  = 1'b0; // [R19]
            if (ev.wdtResetMode) begin
                next_r.flags[RWR_BIT_WDT - 4] = 1'b1;
            end
        end
        case (r.state)
            RWR_RUN: begin
                if (ev.stopMode && ev.wdtTimeout) begin
                    next_r.state      = RWR_WAKE; // [R11]
                    next_r.delay      = delay_for(r.xtal); // [R8]
                    next_r.flags      = 4'b0110; // [R12] [R19]
                    next_r.wdtPending = !ev.wdtResetMode; // [R11]
                end else if (portEdge) begin
                    next_r.state = RWR_WAKE;
                    next_r.delay = delay_for(r.xtal);
                    next_r.flags = 4'b0100; // [R13] [R19] [R21] [R22]
                end
            end
            RWR_WAKE: begin
                if (r.delay == 16'h0) begin
                    next_r.state    = RWR_RUN;
                    next_r.wakeDone = 1'b1;
                    next_r.portData = portPins; // [R14]
                    next_r.portLast = portPins;
                end else if (ev.ioscTick) begin
                    next_r.delay = r.delay - 16'h1; // [R8]
                end
            end
            RWR_RESET: begin
                next_r.dbgReq = 1'b0; // [R7]
                if (r.delay > 16'h0) begin
                    if (ev.ioscTick) begin
                        next_r.delay = r.delay - 16'h1; // [R6]
                    end
                end else if (!pinLow) begin
                    next_r.state = RWR_RUN; // [R2]
                    if (r.pinCaused) begin
                        next_r.flags[RWR_BIT_EXT - 4] = 1'b1; // [R3]
                    end
                end
            end
            default: begin
                next_r.state = RWR_RUN;
            end
        endcase
        if (hardReset) begin
            next_r.state     = RWR_RESET; // [R7] [R11]
            next_r.delay     = delay_for(r.xtal);
            next_r.flags     = 4'b1000; // [R18] [R20] [R21] [R22]
            next_r.pinCaused = 1'b0;
            next_r.dbgReq    = 1'b0;
        end else if (pinReset) begin
            next_r.state     = RWR_RESET; // [R1] [R11]
            next_r.delay     = delay_for(r.xtal);
            next_r.flags     = 4'b0000;
            next_r.pinCaused = 1'b1;
        end else if (wdtReset) begin
            next_r.state     = RWR_RESET;
            next_r.delay     = delay_for(r.xtal); // [R5]
            next_r.flags     = 4'b0010;
            next_r.pinCaused = 1'b0;
        end
        if (r.wdtPending && r.wakeDone) begin
            next_r.wdtPending = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r         <= '0;
            r.state   <= RWR_RESET;
            r.pinSync <= 2'b11;
            r.delay   <= RWR_DELAY_IOSC_W;
            r.flags   <= RWR_FLAGS_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign waitrequest       = busHit;
    assign readdata          = r.rdata;
    assign systemReset       = (r.state == RWR_RESET);
    assign cpuReset          = (r.state == RWR_RESET) || (r.state == RWR_WAKE); // [R8] [R10]
    assign resetPinOut       = 1'b0;
    assign resetPinOe        = (r.state == RWR_RESET) && (r.delay != 16'h0); // [R4] [R5]
    assign wakeDone          = r.wakeDone;
    assign selectIosc        = r.wakeDone || (r.state == RWR_RESET); // [R9]
    assign crystalEnable     = r.xtal;
    assign wdtIrqFollow      = r.wdtPending && r.wakeDone; // [R11] [R12]
    assign vectorAddrLo      = 16'h0002; // [R10]
    assign portInputData     = r.portData;
    assign watchdogControl   = r.wdCtl;
    assign watchdogControlWr = r.wdWr;

    property p_pin_reset;
        @(posedge clk) disable iff (!rst_n)
        (pinLow && !ev.stopMode && r.state == RWR_RUN && !r.dbgReq) [*3] |=> systemReset;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin low did not reset"); // [R1]

    property p_pin_hold;
        @(posedge clk) disable iff (!rst_n)
        (systemReset && pinLow) |=> systemReset;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("left reset with pin low"); // [R2]

    property p_oe;
        @(posedge clk) disable iff (!rst_n)
        (systemReset && r.delay != 16'h0) |-> resetPinOe && !resetPinOut;
    endproperty
    a_oe: assert property (p_oe) else $error("reset pin not driven"); // [R4]

    property p_read_clear;
        @(posedge clk) disable iff (!rst_n)
        (readStatus && !next_r.state[0] && r.state == RWR_RUN && !portEdge && !ev.wdtTimeout)
        |=> r.flags == 4'h0;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flags not cleared"); // [R16]

    property p_reserved;
        @(posedge clk) disable iff (!rst_n)
        r.rdata[3:0] == 4'h0 && r.rdata[31:8] == 24'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set"); // [R23]

    property p_wdt_wake;
        @(posedge clk) disable iff (!rst_n)
        (r.state == RWR_RUN && ev.stopMode && ev.wdtTimeout && !ev.porEvent && !ev.brownout
         && !r.dbgReq && !ev.debugPinLow && !pinReset) |=> r.flags == 4'b0110 && cpuReset;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake flags wrong"); // [R12]

    sequence s_dbg_done;
        systemReset ##1 !r.dbgReq;
    endsequence

    property p_dbg_clear;
        @(posedge clk) disable iff (!rst_n)
        r.dbgReq |=> s_dbg_done;
    endproperty
    a_dbg_clear: assert property (p_dbg_clear) else $error("debug request stuck"); // [R7]

    property p_ack;
        @(posedge clk) disable iff (!rst_n)
        (bus.read || bus.write) && waitrequest |=> !waitrequest;
    endproperty
    a_ack: assert property (p_ack) else $error("bus not answered"); // [R17]

    property p_int_reset;
        @(posedge clk) disable iff (!rst_n)
        (ev.porEvent || ev.brownout) |=> systemReset && resetPinOe;
    endproperty
    a_int_reset: assert property (p_int_reset) else $error("internal reset not driven"); // [R5]

    property p_hard_cause;
        @(posedge clk) disable iff (!rst_n)
        hardReset |=> systemReset && r.flags == 4'b1000;
    endproperty
    a_hard_cause: assert property (p_hard_cause) else $error("power-on cause wrong"); // [R7] [R18]

    property p_wdt_cause;
        @(posedge clk) disable iff (!rst_n)
        (wdtReset && !hardReset && !pinReset) |=> systemReset && r.flags == 4'b0010;
    endproperty
    a_wdt_cause: assert property (p_wdt_cause) else $error("watchdog cause wrong"); // [R18]

    property p_port_wake;
        @(posedge clk) disable iff (!rst_n)
        (r.state == RWR_RUN && portEdge && !ev.wdtTimeout && !resetReq)
        |=> r.state == RWR_WAKE && r.flags == 4'b0100;
    endproperty
    a_port_wake: assert property (p_port_wake) else $error("pin wake wrong"); // [R13]

    sequence s_wake_exit;
        wakeDone && selectIosc && !cpuReset;
    endsequence

    property p_wake_exit;
        @(posedge clk) disable iff (!rst_n)
        (r.state == RWR_WAKE && r.delay == 16'h0 && !resetReq) |=> s_wake_exit;
    endproperty
    a_wake_exit: assert property (p_wake_exit) else $error("wake did not end"); // [R8] [R9]

    property p_reset_tick;
        @(posedge clk) disable iff (!rst_n)
        (systemReset && r.delay != 16'h0 && ev.ioscTick && !resetReq)
        |=> r.delay == $past(r.delay) - 16'h1;
    endproperty
    a_reset_tick: assert property (p_reset_tick) else $error("reset delay not counted"); // [R6]

    property p_wd_write;
        @(posedge clk) disable iff (!rst_n)
        (bus.write && waitrequest && bus.address == RWR_ADDR_STATUS)
        |=> watchdogControlWr && watchdogControl == $past(bus.writedata[7:0]);
    endproperty
    a_wd_write: assert property (p_wd_write) else $error("watchdog write lost"); // [R17]

    property p_read_data;
        @(posedge clk) disable iff (!rst_n)
        readStatus |=> !waitrequest && readdata == {24'h0, $past(r.flags), 4'h0};
    endproperty
    a_read_data: assert property (p_read_data) else $error("status read wrong"); // [R16] [R18]

    property p_capture;
        @(posedge clk) disable iff (!rst_n)
        wakeDone |-> portInputData == $past(portPins);
    endproperty
    a_capture: assert property (p_capture) else $error("port data not captured"); // [R14]

    property p_stop_filter;
        @(posedge clk) disable iff (!rst_n)
        (ev.stopMode && r.state == RWR_RUN && r.lowCount < 4'h6 && !hardReset && !ev.wdtTimeout
         && !portEdge) |=> !systemReset;
    endproperty
    a_stop_filter: assert property (p_stop_filter) else $error("short pulse reset"); // [R15]

    property p_ext_flag;
        @(posedge clk) disable iff (!rst_n)
        (systemReset && r.delay == 16'h0 && !pinLow && r.pinCaused && !resetReq)
        |=> !systemReset && r.flags[RWR_BIT_EXT - 4];
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("external flag not set"); // [R3]
endmodule : rwr_reset_ctrl

// ---- include/rwr_pkg.sv ----
/*
 Package for the reset and wake recovery controller: register map, cause
 flag layout, sequencer states, delay counts and grouped port structs.
 Assumes a single 100 MHz system clock and an internal oscillator tick.
*/
package rwr_pkg;
    localparam logic [11:0] RWR_ADDR_STATUS   = 12'hff0;
    localparam logic [11:0] RWR_ADDR_CONTROL  = 12'hff4;
    localparam int          RWR_BIT_POR       = 7;
    localparam int          RWR_BIT_WAKE      = 6;
    localparam int          RWR_BIT_WDT       = 5;
    localparam int          RWR_BIT_EXT       = 4;
    localparam logic [3:0]  RWR_FLAGS_RESET   = 4'h8;
    localparam int          RWR_CTL_XTAL      = 0;
    localparam int          RWR_CTL_DBGRST    = 1;
    localparam int          RWR_PIN_LOW_MIN   = 4;
    localparam int          RWR_DELAY_IOSC    = 66;
    localparam int          RWR_DELAY_XTAL    = 5000;
    localparam int          RWR_STOP_FILTER   = 8;
    localparam logic [15:0] RWR_DELAY_IOSC_W  = 16'(RWR_DELAY_IOSC);
    localparam logic [31:0] RWR_READ_ZERO     = 32'h0000_0000;

    typedef enum logic [1:0] {
        RWR_RUN   = 2'b00,
        RWR_RESET = 2'b01,
        RWR_WAKE  = 2'b10,
        RWR_HOLD  = 2'b11
    } rwr_state_t;

    typedef struct packed {
        logic [11:0] address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } rwr_bus_req_t;

    typedef struct packed {
        logic        porEvent;
        logic        brownout;
        logic        wdtTimeout;
        logic        wdtResetMode;
        logic        stopMode;
        logic        debugPinLow;
        logic        ioscTick;
    } rwr_event_t;
endpackage : rwr_pkg

// ---- verification/rwr_pin_partner.sv ----
/*
 Far side of the open-drain reset pin: a board source that may pull it low.
 Assumes an external pull-up keeps the wire high when nobody drives it.
*/
`timescale 1ns/1ps
module rwr_pin_partner (
    // Commanded drive from the bench
    input  wire logic holdLow,
    // Device side of the pin
    input  wire logic resetPinOut,
    input  wire logic resetPinOe,
    // Resolved wire level
    output logic      pinLevel
);
    // Wired-and of both drivers over the pull-up
    assign pinLevel = ((resetPinOe && !resetPinOut) || holdLow) ? 1'b0 : 1'b1;
endmodule : rwr_pin_partner

// ---- verification/tb_rwr_reset_ctrl.sv ----
/*
 Self-checking bench for the reset and wake recovery sequencer.
 Assumes 100 MHz clk, an oscillator tick every second cycle, short crystal count.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin nErrors++; $display("wrong value at %0t: got %0h expected %0h", $time, a, b); end end
module tb_rwr_reset_ctrl;
    import rwr_pkg::*;
    localparam int PORTS = 8;
    logic clk = 1'b0, rst_n = 1'b0, holdLow = 1'b0, pinLevel;
    rwr_bus_req_t bus = '0;
    rwr_event_t ev = '0;
    logic [PORTS-1:0] wakeEnable = '0, portPins = '0, portInputData;
    logic [31:0] readdata;
    logic [15:0] vectorAddrLo;
    logic [7:0] watchdogControl;
    logic waitrequest, resetPinOut, resetPinOe, cpuReset, systemReset, wakeDone;
    logic selectIosc, crystalEnable, wdtIrqFollow, watchdogControlWr;
    int nErrors = 0, checkCount = 0, seed = 44;
    int expQ[$];
    int expTab[8] = '{'h80, 'h80, 'h20, 'h10, 'h80, 'h80, 'h60, 'h40};

    rwr_reset_ctrl #(.PORTS(PORTS), .XTAL_CYC(20)) rwr_reset_ctrl_i (
        .clk(clk), .rst_n(rst_n), .bus(bus), .readdata(readdata), .waitrequest(waitrequest),
        .resetPinIn(pinLevel), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .ev(ev),
        .wakeEnable(wakeEnable), .portPins(portPins), .cpuReset(cpuReset),
        .systemReset(systemReset), .wakeDone(wakeDone), .selectIosc(selectIosc),
        .crystalEnable(crystalEnable), .wdtIrqFollow(wdtIrqFollow), .vectorAddrLo(vectorAddrLo),
        .portInputData(portInputData), .watchdogControl(watchdogControl),
        .watchdogControlWr(watchdogControlWr));
    rwr_pin_partner rwr_pin_partner_i (.holdLow(holdLow), .resetPinOut(resetPinOut),
        .resetPinOe(resetPinOe), .pinLevel(pinLevel));

    always #5 clk = ~clk;
    always @(posedge clk) ev.ioscTick <= ~ev.ioscTick;

    task report_and_stop;
        $display("checks %0d mismatches %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    task automatic bus_xfer(input logic [11:0] a, input logic wr, input logic [31:0] wd,
                            output logic [31:0] rd);
        int k;
        @(posedge clk);
        bus <= '{a, ~wr, wr, wd};
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        rd = readdata;
        bus <= '0;
        if (k == 50) begin
            nErrors++;
            report_and_stop();
        end
    endtask : bus_xfer

    task automatic wait_for(input int sel, output int n);
        for (n = 0; n < 20000; n++) begin
            @(negedge clk);
            if ((sel == 0 && systemReset === 1'b1) || (sel == 1 && cpuReset === 1'b0) ||
                (sel == 2 && wakeDone === 1'b1)) break;
        end
        if (n == 20000) begin
            nErrors++;
            report_and_stop();
        end
    endtask : wait_for

    task automatic read_status;
        logic [31:0] d;
        int e;
        e = expQ.pop_front();
        bus_xfer(RWR_ADDR_STATUS, 1'b0, '0, d);
        `CHK(d, 32'(e))
        bus_xfer(RWR_ADDR_STATUS, 1'b0, '0, d);
        `CHK(d, 32'h0)
    endtask : read_status

    task automatic run_case(input int k);
        logic [31:0] d;
        int n, cyc;
        @(posedge clk);
        case (k)
            0: ev.porEvent <= 1'b1;
            1: ev.brownout <= 1'b1;
            2: begin ev.wdtResetMode <= 1'b1; ev.wdtTimeout <= 1'b1; end
            3: holdLow <= 1'b1;
            4: begin ev.stopMode <= 1'b1; ev.debugPinLow <= 1'b1; end
            5: bus_xfer(RWR_ADDR_CONTROL, 1'b1, 32'h2, d);
            6: begin ev.stopMode <= 1'b1; ev.wdtResetMode <= 1'b0; ev.wdtTimeout <= 1'b1; end
            default: begin ev.stopMode <= 1'b1; @(posedge clk); portPins <= portPins ^ wakeEnable; end
        endcase
        @(posedge clk);
        {ev.porEvent, ev.brownout, ev.wdtTimeout, ev.debugPinLow} <= '0;
        if (k < 6) begin
            wait_for(0, n);
            `CHK(resetPinOe, 1'b1)
            if (k == 3) begin
                repeat (198) @(posedge clk);
                @(negedge clk);
                `CHK(cpuReset, 1'b1)
                `CHK(resetPinOe, 1'b0)
                n = 199;
                @(posedge clk);
                holdLow <= 1'b0;
            end
            wait_for(1, cyc);
            `CHK(1'(cyc + n >= 130), 1'b1)
        end else begin
            wait_for(2, cyc);
            `CHK(1'(cyc >= 130), 1'b1)
            `CHK(selectIosc, 1'b1)
            `CHK(wdtIrqFollow, 1'(k == 6))
            if (k == 7) `CHK(portInputData, portPins)
            @(posedge clk);
            ev.stopMode <= 1'b0;
            wait_for(1, n);
        end
        `CHK(vectorAddrLo, 16'h0002)
        expQ.push_back(expTab[k]);
        read_status();
        $display("test %0d done", k);
    endtask : run_case

    initial begin
        logic [31:0] d, w;
        int n;
        wakeEnable = PORTS'($random(seed)) | PORTS'(1);
        portPins = PORTS'($random(seed));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        wait_for(1, n);
        expQ.push_back('h80);
        read_status();
        w = $random(seed);
        bus_xfer(RWR_ADDR_STATUS, 1'b1, w, d);
        @(negedge clk);
        `CHK(watchdogControl, w[7:0])
        bus_xfer(12'h100, 1'b0, '0, d);
        `CHK(d, 32'h0)
        bus_xfer(RWR_ADDR_STATUS, 1'b0, '0, d);
        `CHK(d, 32'h0)
        $display("test bus done");
        for (int k = 0; k < 8; k++) run_case(k);
        report_and_stop();
    end
endmodule : tb_rwr_reset_ctrl
